/* common/uoct_consts.vh */
`ifndef UOCT_CONSTS_VH
`define UOCT_CONSTS_VH
// channel register offsets within A3:A0
`define UOCT_OFS_HOLDING     4'h0
`define UOCT_OFS_INT_ENABLE  4'h1
`define UOCT_OFS_INT_STATUS  4'h2
`define UOCT_OFS_MODEM_CTRL  4'h4
// address field positions
`define UOCT_ADDR_GLOBAL_BIT 7
`define UOCT_ADDR_CHAN_HI    6
`define UOCT_ADDR_CHAN_LO    4
// field positions
`define UOCT_MCR_IR_BIT      6
`define UOCT_IER_RSVD_BIT    4
`define UOCT_IER_EFR_MASK    8'hE0
`define UOCT_IER_FREE_MASK   8'h0F
// reset values
`define UOCT_IER_RESET       8'h00
`define UOCT_ISR_RESET       8'h01
// interrupt identification codes, six bits
`define UOCT_ID_LINE_ERR     6'h06
`define UOCT_ID_RX_READY     6'h04
`define UOCT_ID_RX_TIMEOUT   6'h0C
`define UOCT_ID_TX_READY     6'h02
`define UOCT_ID_MODEM        6'h00
`define UOCT_ID_FLOW         6'h10
`define UOCT_ID_CTS_RTS      6'h20
`define UOCT_ID_NONE         6'h01
// fifo geometry
`define UOCT_FIFO_DEPTH      7'h40
`define UOCT_PTR_W           7
// infrared pulse lengths in sample ticks of sixteen per bit
`define UOCT_IR10_TICKS      3'h3
`define UOCT_IR11_TICKS      3'h4
`define UOCT_SAMPLES_PER_BIT 5'h10
// reset capture delay, covers the pin synchroniser
`define UOCT_STRAP_DELAY     2'h3
`endif

/* verilog/uoct_channel.v */
`timescale 1ns/1ns
`default_nettype none
`include "uoct_consts.vh"

// How it works
// R01 - broadcast bit set: any channel write lands in all eight channels
// R02 - host clears broadcast bit before reads; mode changes may disturb traffic
// R03 - IrDA 1.0: three-sixteenths bit high pulse per zero bit, to 115.2k
// R04 - IrDA 1.1: quarter bit high pulse per zero bit, to 1.152M
// R05 - modem control bit 6 enables infrared coding, IrDA 1.0 by default
// R06 - infrared plus auxiliary status bit 4 selects IrDA 1.1
// R07 - infrared mode: transmit idles low, receive treated as idling low
// R08 - infrared decoder turns each light pulse into a logic 1
// R09 - after hard or soft reset infrared mode starts from default pin
// R10 - reading receive holding returns and removes oldest entry
// R11 - writing transmit holding appends byte; full fifo discards it
// R12 - holding, enable and status registers only reachable with divisor access 0
// R13 - enable bits: CTS, RTS, flow, reserved, modem, line, tx, rx
// R14 - tx ready: holding empty without fifo, space above trigger with fifo
// R15 - upper three enable bits writable only with enhanced function enabled
// R16 - status bit 0 low while enabled interrupt pending
// R17 - status bits 7 and 6 mirror fifo enable
// R18 - priority: line error, rx ready, rx timeout
// R19 - then tx ready, modem, flow, CTS/RTS; none reads 000001
// R20 - flow flag clears on Xon after Xoff, or status read after special char
// R21 - A7 low: A6:A4 pick channel, A3:A0 register; A7 high global
// R22 - pulse width counted in sample ticks, three or four of sixteen
module uoct_channel #(
    parameter [2:0] CHANNEL_ID = 3'h0
) (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       clk_en,
    input  wire       soft_rst,
    input  wire       cs_n,
    input  wire       ior_n,
    input  wire       iow_n,
    input  wire [7:0] addr,
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output wire       data_oe,
    input  wire       broadcast_write_control,
    input  wire       divisor_access,
    input  wire       enhanced_function_en,
    input  wire       fifo_enable,
    input  wire       irda11_select,
    input  wire       infrared_default_pin,
    input  wire       rx_line_err,
    input  wire       rx_timeout,
    input  wire       modem_status_evt,
    input  wire       xoff_detect,
    input  wire       xon_detect,
    input  wire       special_char_detect,
    input  wire       cts_inactive_evt,
    input  wire       rts_inactive_evt,
    input  wire       tx_above_trigger,
    input  wire       tx_pop,
    output reg  [7:0] tx_data,
    output reg        tx_data_valid,
    output wire       tx_avail,
    input  wire       rx_push,
    input  wire [7:0] rx_push_data,
    output wire       rx_full,
    input  wire       sample_tick,
    input  wire       tx_bit_start,
    input  wire       tx_serial,
    output reg        tx_pin,
    input  wire       rx_pin,
    output reg        rx_serial,
    output wire       infrared_mode,
    output wire       irq_pending
);

    // channel match for reads, and for writes unless broadcast overrides it
    function chan_hit;
        input [7:0] a;
        input       bcast;
        begin
            chan_hit = ~a[`UOCT_ADDR_GLOBAL_BIT] &
                       (bcast | (a[`UOCT_ADDR_CHAN_HI:`UOCT_ADDR_CHAN_LO] == CHANNEL_ID)); // [R21]
        end
    endfunction

    // pin synchronisers: first stage is read only by the second
    reg  [2:0]  ctl_m_q;
    reg  [2:0]  ctl_s_q;
    reg  [15:0] bus_m_q;
    reg  [15:0] bus_s_q;
    reg  [1:0]  pin_m_q;
    reg  [1:0]  pin_s_q;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_m_q <= 3'h0;
            ctl_s_q <= 3'h0;
            bus_m_q <= 16'h0000;
            bus_s_q <= 16'h0000;
            pin_m_q <= 2'h0;
            pin_s_q <= 2'h0;
        end else if (clk_en) begin
            ctl_m_q <= {~cs_n & ~iow_n, ~cs_n & ~ior_n, 1'b0};
            ctl_s_q <= ctl_m_q;
            bus_m_q <= {addr, data_in};
            bus_s_q <= bus_m_q;
            pin_m_q <= {infrared_default_pin, rx_pin};
            pin_s_q <= pin_m_q;
        end
    end

    wire       wr_act = ctl_s_q[2];
    wire       rd_act = ctl_s_q[1];
    wire       strap  = pin_s_q[1];
    wire       rx_s   = pin_s_q[0];

    // hold the address and data seen during a cycle, act when the strobe ends
    reg        wr_act_q;
    reg        rd_act_q;
    reg  [7:0] lat_addr_q;
    reg  [7:0] lat_data_q;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_act_q   <= 1'b0;
            rd_act_q   <= 1'b0;
            lat_addr_q <= 8'h00;
            lat_data_q <= 8'h00;
        end else if (clk_en) begin
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
            if (wr_act | rd_act) begin
                lat_addr_q <= bus_s_q[15:8];
                lat_data_q <= bus_s_q[7:0];
            end
        end
    end

    wire       wr_end  = wr_act_q & ~wr_act;
    wire       rd_end  = rd_act_q & ~rd_act;
    wire [3:0] reg_ofs = lat_addr_q[3:0];
    wire       wr_hit  = wr_end & chan_hit(lat_addr_q, broadcast_write_control); // [R01]
    wire       rd_sel  = chan_hit(bus_s_q[15:8], 1'b0);
    wire       rd_hit  = rd_end & chan_hit(lat_addr_q, 1'b0);
    wire       norm_ok = ~divisor_access; // [R12]
    wire       wr_thr  = wr_hit & norm_ok & (reg_ofs == `UOCT_OFS_HOLDING);
    wire       wr_ier  = wr_hit & norm_ok & (reg_ofs == `UOCT_OFS_INT_ENABLE);
    wire       wr_mcr  = wr_hit & (reg_ofs == `UOCT_OFS_MODEM_CTRL);
    wire       rd_rhr  = rd_hit & norm_ok & (reg_ofs == `UOCT_OFS_HOLDING);
    wire       rd_isr  = rd_hit & norm_ok & (reg_ofs == `UOCT_OFS_INT_STATUS);

    wire [6:0] cap = fifo_enable ? `UOCT_FIFO_DEPTH : 7'h01;

    // transmit fifo: host appends, transmitter pops
    reg  [7:0] tx_mem [0:63];
    reg  [6:0] tx_wp_q;
    reg  [6:0] tx_rp_q;
    wire [6:0] tx_cnt  = tx_wp_q - tx_rp_q;
    wire       tx_full = (tx_cnt >= cap);
    assign tx_avail = (tx_cnt != 7'h00);
    always @(posedge clk) begin
        if (clk_en && wr_thr && !tx_full) begin
            tx_mem[tx_wp_q[5:0]] <= lat_data_q;
        end
    end
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_wp_q       <= 7'h00;
            tx_rp_q       <= 7'h00;
            tx_data       <= 8'h00;
            tx_data_valid <= 1'b0;
        end else if (clk_en) begin
            tx_data_valid <= 1'b0;
            if (soft_rst) begin
                tx_wp_q <= 7'h00;
                tx_rp_q <= 7'h00;
            end else begin
                if (wr_thr && !tx_full)
                    tx_wp_q <= tx_wp_q + 7'h01; // [R11]
                if (tx_pop && tx_avail) begin
                    tx_data       <= tx_mem[tx_rp_q[5:0]];
                    tx_data_valid <= 1'b1;
                    tx_rp_q       <= tx_rp_q + 7'h01;
                end
            end
        end
    end

    // receive fifo: receiver pushes, host read removes the oldest byte
    reg  [7:0] rx_mem [0:63];
    reg  [6:0] rx_wp_q;
    reg  [6:0] rx_rp_q;
    wire [6:0] rx_cnt   = rx_wp_q - rx_rp_q;
    wire       rx_ready = (rx_cnt != 7'h00);
    assign rx_full = (rx_cnt >= cap);
    always @(posedge clk) begin
        if (clk_en && rx_push && !rx_full) begin
            rx_mem[rx_wp_q[5:0]] <= rx_push_data;
        end
    end
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_wp_q <= 7'h00;
            rx_rp_q <= 7'h00;
        end else if (clk_en) begin
            if (soft_rst) begin
                rx_wp_q <= 7'h00;
                rx_rp_q <= 7'h00;
            end else begin
                if (rx_push && !rx_full)
                    rx_wp_q <= rx_wp_q + 7'h01;
                if (rd_rhr && rx_ready)
                    rx_rp_q <= rx_rp_q + 7'h01; // [R10]
            end
        end
    end

    // interrupt enable mask, upper bits guarded, bit 4 always zero
    reg  [7:0] ier_q;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ier_q <= `UOCT_IER_RESET;
        end else if (clk_en) begin
            if (soft_rst)
                ier_q <= `UOCT_IER_RESET;
            else if (wr_ier) begin
                ier_q[3:0] <= lat_data_q[3:0]; // [R13]
                if (enhanced_function_en)
                    ier_q[7:5] <= lat_data_q[7:5]; // [R15]
            end
        end
    end

    // flow flag: xoff or special char set it; set wins over clear
    reg        flow_q;
    reg        flow_xoff_q;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flow_q      <= 1'b0;
            flow_xoff_q <= 1'b0;
        end else if (clk_en) begin
            if (soft_rst) begin
                flow_q <= 1'b0;
            end else if (xoff_detect | special_char_detect) begin
                flow_q      <= 1'b1;
                flow_xoff_q <= xoff_detect;
            end else if ((xon_detect & flow_xoff_q) | (rd_isr & ~flow_xoff_q)) begin
                flow_q <= 1'b0; // [R20]
            end
        end
    end

    // prioritised interrupt identification
    wire       p_line  = ier_q[2] & rx_line_err;
    wire       p_rdy   = ier_q[0] & rx_ready;
    wire       p_tout  = ier_q[0] & rx_timeout;
    wire       p_thr   = ier_q[1] & (fifo_enable ? tx_above_trigger : ~tx_avail); // [R14]
    wire       p_modem = ier_q[3] & modem_status_evt;
    wire       p_flow  = ier_q[5] & flow_q;
    wire       p_ctrts = (ier_q[7] & cts_inactive_evt) | (ier_q[6] & rts_inactive_evt);
    reg  [5:0] int_id;
    always @* begin
        if (p_line)
            int_id = `UOCT_ID_LINE_ERR; // [R18]
        else if (p_rdy)
            int_id = `UOCT_ID_RX_READY;
        else if (p_tout)
            int_id = `UOCT_ID_RX_TIMEOUT;
        else if (p_thr)
            int_id = `UOCT_ID_TX_READY; // [R19]
        else if (p_modem)
            int_id = `UOCT_ID_MODEM;
        else if (p_flow)
            int_id = `UOCT_ID_FLOW;
        else if (p_ctrts)
            int_id = `UOCT_ID_CTS_RTS;
        else
            int_id = `UOCT_ID_NONE;
    end
    assign irq_pending = ~int_id[0]; // [R16]
    wire [7:0] isr_val = {fifo_enable, fifo_enable, int_id}; // [R17]

    // read data register, refreshed while the read strobe is held
    reg        ir_mode_q;
    assign data_oe = rd_act & rd_sel;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_out <= `UOCT_ISR_RESET;
        end else if (clk_en && rd_act) begin
            if (!norm_ok)
                data_out <= 8'h00;
            else if (bus_s_q[11:8] == `UOCT_OFS_HOLDING)
                data_out <= rx_mem[rx_rp_q[5:0]];
            else if (bus_s_q[11:8] == `UOCT_OFS_INT_ENABLE)
                data_out <= ier_q;
            else if (bus_s_q[11:8] == `UOCT_OFS_INT_STATUS)
                data_out <= isr_val;
            else if (bus_s_q[11:8] == `UOCT_OFS_MODEM_CTRL)
                data_out <= {1'b0, ir_mode_q, 6'h00};
            else
                data_out <= 8'h00;
        end
    end

    // infrared enable, loaded from the strap once the synchroniser has settled
    reg  [1:0] strap_wait_q;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ir_mode_q    <= 1'b0;
            strap_wait_q <= `UOCT_STRAP_DELAY;
        end else if (clk_en) begin
            if (soft_rst) begin
                strap_wait_q <= `UOCT_STRAP_DELAY;
            end else if (strap_wait_q != 2'h0) begin
                strap_wait_q <= strap_wait_q - 2'h1;
                if (strap_wait_q == 2'h1)
                    ir_mode_q <= strap; // [R09]
            end else if (wr_mcr) begin
                ir_mode_q <= lat_data_q[`UOCT_MCR_IR_BIT]; // [R05]
            end
        end
    end
    assign infrared_mode = ir_mode_q;

    // encoder: high pulse of three or four ticks at the start of each zero bit
    wire [2:0] pulse_len = irda11_select ? `UOCT_IR11_TICKS : `UOCT_IR10_TICKS; // [R06]
    reg  [2:0] enc_cnt_q;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            enc_cnt_q <= 3'h0;
        end else if (clk_en) begin
            if (tx_bit_start && !tx_serial)
                enc_cnt_q <= pulse_len; // [R03] [R04]
            else if (sample_tick && enc_cnt_q != 3'h0)
                enc_cnt_q <= enc_cnt_q - 3'h1; // [R22]
        end
    end

    // decoder: a rising light pulse yields a one lasting one bit time
    reg        rx_prev_q;
    reg  [4:0] dec_cnt_q;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_prev_q <= 1'b0;
            dec_cnt_q <= 5'h00;
        end else if (clk_en) begin
            rx_prev_q <= rx_s;
            if (rx_s && !rx_prev_q)
                dec_cnt_q <= `UOCT_SAMPLES_PER_BIT; // [R08]
            else if (sample_tick && dec_cnt_q != 5'h00)
                dec_cnt_q <= dec_cnt_q - 5'h01;
        end
    end

    // line pins: infrared idles low both ways, otherwise plain pass-through
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_pin    <= 1'b1;
            rx_serial <= 1'b1;
        end else if (clk_en) begin
            if (ir_mode_q) begin
                tx_pin    <= (enc_cnt_q != 3'h0); // [R07]
                rx_serial <= (dec_cnt_q != 5'h00);
            end else begin
                tx_pin    <= tx_serial;
                rx_serial <= rx_s;
            end
        end
    end

endmodule // uoct_channel
`default_nettype wire

/* dv/uoct_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module uoct_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] data_out,
    output var  logic       cs_n,
    output var  logic       ior_n,
    output var  logic       iow_n,
    output var  logic [7:0] addr,
    output var  logic [7:0] data_in
);
    // idle bus: nothing selected
    initial begin
        {cs_n, ior_n, iow_n} = 3'h7;
        {addr, data_in} = 16'h0000;
    end
    // one strobe held five edges, released lines show the inverse, then a rest
    task automatic cyc(input logic [7:0] a, input logic [7:0] d, input logic rd, output logic [7:0] q);
        @(posedge clk);
        #1;
        addr = a;
        data_in = d;
        {cs_n, ior_n, iow_n} = {1'b0, !rd, rd};
        repeat (5) @(posedge clk);
        q = data_out;
        #1;
        {cs_n, ior_n, iow_n} = 3'h7;
        addr = ~a;
        data_in = ~d;
        repeat (4) @(posedge clk);
        #1;
    endtask
endmodule // uoct_host_model
`default_nettype wire

/* dv/uoct_channel_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module uoct_channel_chk (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       cs_n,
    input wire logic       ior_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    input wire logic       divisor_access,
    input wire logic       fifo_enable,
    input wire logic       tx_pop,
    input wire logic       tx_data_valid,
    input wire logic       tx_avail,
    input wire logic       rx_push,
    input wire logic       rx_full,
    input wire logic       sample_tick,
    input wire logic       tx_bit_start,
    input wire logic       tx_serial,
    input wire logic       tx_pin,
    input wire logic       infrared_mode,
    input wire logic       irq_pending
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [3:0] hi_ticks_q;
    // sample ticks seen while an infrared pulse is high
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hi_ticks_q <= 4'h0;
        end else if (!tx_pin || !infrared_mode) begin
            hi_ticks_q <= 4'h0;
        end else if (sample_tick && hi_ticks_q != 4'hF) begin
            hi_ticks_q <= hi_ticks_q + 4'h1;
        end
    end
    // a status read held steady for three cycles
    sequence s_isr_rd;
        data_oe && $past(data_oe,3) && addr[3:0] == 4'h2 && $past(addr,3) == addr && !divisor_access;
    endsequence
    a_oe_needs_strobe: assert property (data_oe |-> !$past(cs_n,2) && !$past(ior_n,2) && !$past(addr[7],2))
        else $error("read drive without a selected read strobe");
    a_pop_gives_data: assert property (tx_pop && tx_avail |=> tx_data_valid)
        else $error("pop gave no data");
    a_valid_needs_pop: assert property (tx_data_valid |-> $past(tx_pop) && $past(tx_avail))
        else $error("data valid without a pop");
    a_txq_only_pops: assert property ($fell(tx_avail) |-> $past(tx_pop))
        else $error("transmit queue emptied without a pop");
    a_rxq_full_push: assert property ($rose(rx_full) |-> $past(rx_push))
        else $error("receive queue filled without a push");
    a_plain_tx_path: assert property (!infrared_mode && !$past(infrared_mode) && !$past(sys_rst)
        |-> tx_pin == $past(tx_serial))
        else $error("plain transmit pin does not follow data");
    a_ir_rise_cause: assert property (infrared_mode && $past(infrared_mode,2) && $rose(tx_pin)
        |-> $past(tx_bit_start) && !$past(tx_serial) || $past(tx_bit_start,2) && !$past(tx_serial,2))
        else $error("infrared pulse without a zero bit");
    a_ir_pulse_ticks: assert property (infrared_mode && $past(infrared_mode,2) && $fell(tx_pin)
        |-> $past(hi_ticks_q) >= 4'h3 && $past(hi_ticks_q) <= 4'h5)
        else $error("infrared pulse length out of range");
    a_isr_mirror: assert property (s_isr_rd |-> data_out[7:6] == {2{$past(fifo_enable)}})
        else $error("status top bits differ from queue enable");
    a_isr_pending: assert property (s_isr_rd |-> data_out[0] == !$past(irq_pending))
        else $error("status bit zero disagrees with pending");
endmodule // uoct_channel_chk
bind uoct_channel uoct_channel_chk chk_u (.clk, .sys_rst, .cs_n, .ior_n, .addr, .data_out, .data_oe,
    .divisor_access, .fifo_enable, .tx_pop, .tx_data_valid, .tx_avail, .rx_push, .rx_full,
    .sample_tick, .tx_bit_start, .tx_serial, .tx_pin, .infrared_mode, .irq_pending);
`default_nettype wire

/* dv/uoct_channel_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "uoct_consts.vh"
module uoct_channel_tb_top;
    localparam logic [7:0] A_HOLD = {4'h0, `UOCT_OFS_HOLDING};
    localparam logic [7:0] A_IER  = {4'h0, `UOCT_OFS_INT_ENABLE};
    localparam logic [7:0] A_ISR  = {4'h0, `UOCT_OFS_INT_STATUS};
    localparam logic [7:0] A_MCR  = {4'h0, `UOCT_OFS_MODEM_CTRL};
    logic       clk, sys_rst, clk_en, soft_rst, cs_n, ior_n, iow_n, data_oe, broadcast_write_control;
    logic [7:0] addr, data_in, data_out, tx_data, rx_push_data, rd_q;
    logic       divisor_access, enhanced_function_en, fifo_enable, irda11_select, infrared_default_pin;
    logic       rx_line_err, rx_timeout, modem_status_evt, xoff_detect, xon_detect, special_char_detect;
    logic       cts_inactive_evt, rts_inactive_evt, tx_above_trigger, tx_pop, tx_data_valid, tx_avail;
    logic       rx_push, rx_full, sample_tick, tx_bit_start, tx_serial, tx_pin, rx_pin, rx_serial;
    logic       infrared_mode, irq_pending;
    logic [1:0] tick_cnt;
    int         failures, samples_checked, hi_cnt;

    uoct_channel dut_u (.*);
    uoct_host_model host_u (.*);

    always #5 clk = ~clk;
    // sample ticks every fourth clock
    always @(posedge clk) begin
        #1;
        tick_cnt = tick_cnt + 2'h1;
        sample_tick = (tick_cnt == 2'h0);
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.cyc(a, d, 1'b0, rd_q);
    endtask
    task automatic rd(input logic [7:0] a);
        host_u.cyc(a, 8'h00, 1'b1, rd_q);
    endtask
    task automatic pop(input logic [7:0] e);
        tx_pop = 1'b1;
        step(1);
        tx_pop = 1'b0;
        chk("tx_valid", 8'h01, {7'h00, tx_data_valid});
        chk("tx_data", e, tx_data);
    endtask
    task automatic end_sim;
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // strap start-up, reset status, mode bit
    task automatic t_reset;
        chk("ir_strap", 8'h01, {7'h00, infrared_mode});
        chk("ir_idle", 8'h00, {7'h00, tx_pin});
        rd(A_ISR);
        chk("isr_reset", `UOCT_ISR_RESET, rd_q);
        wr(A_MCR, 8'h00);
        chk("ir_off", 8'h00, {7'h00, infrared_mode});
    endtask
    // enable mask with the upper bits locked and unlocked
    task automatic t_ier;
        wr(A_IER, 8'hFF);
        rd(A_IER);
        chk("ier_locked", 8'h0F, rd_q);
        enhanced_function_en = 1'b1;
        wr(A_IER, 8'hFF);
        rd(A_IER);
        chk("ier_open", 8'hEF, rd_q);
        enhanced_function_en = 1'b0;
        wr(A_IER, 8'h00);
        rd(A_IER);
        chk("ier_keep", 8'hE0, rd_q);
        enhanced_function_en = 1'b1;
        wr(A_IER, 8'hEF);
    endtask
    // sources raised from lowest to highest priority
    task automatic t_prio;
        logic [5:0] ids [7];
        ids = '{`UOCT_ID_CTS_RTS, `UOCT_ID_FLOW, `UOCT_ID_MODEM, `UOCT_ID_TX_READY,
                `UOCT_ID_RX_TIMEOUT, `UOCT_ID_RX_READY, `UOCT_ID_LINE_ERR};
        fifo_enable = 1'b1;
        for (int i = 0; i < 7; i++) begin
            case (i)
                0: cts_inactive_evt = 1'b1;
                1: xoff_detect = 1'b1;
                2: modem_status_evt = 1'b1;
                3: tx_above_trigger = 1'b1;
                4: rx_timeout = 1'b1;
                5: rx_push = 1'b1;
                default: rx_line_err = 1'b1;
            endcase
            step(1);
            {xoff_detect, rx_push} = 2'b00;
            rd(A_ISR);
            chk("isr_prio", {2'b11, ids[i]}, rd_q);
            chk("irq_busy", 8'h01, {7'h00, irq_pending});
        end
        rx_line_err = 1'b0;
        rd(A_HOLD);
        chk("rx_data", 8'h5A, rd_q);
        {rx_timeout, tx_above_trigger, modem_status_evt} = 3'b000;
        rd(A_ISR);
        chk("isr_flow", {2'b11, `UOCT_ID_FLOW}, rd_q);
        xon_detect = 1'b1;
        step(1);
        xon_detect = 1'b0;
        cts_inactive_evt = 1'b0;
        rd(A_ISR);
        chk("isr_none", {2'b11, `UOCT_ID_NONE}, rd_q);
        chk("irq_idle", 8'h00, {7'h00, irq_pending});
        special_char_detect = 1'b1;
        step(1);
        special_char_detect = 1'b0;
        rd(A_ISR);
        chk("isr_special", {2'b11, `UOCT_ID_FLOW}, rd_q);
        rts_inactive_evt = 1'b1;
        rd(A_ISR);
        chk("isr_rts", {2'b11, `UOCT_ID_CTS_RTS}, rd_q);
        rts_inactive_evt = 1'b0;
    endtask
    // single-entry queues, divisor lock-out, broadcast writes
    task automatic t_fifo;
        fifo_enable = 1'b0;
        rx_push_data = 8'hA7;
        rx_push = 1'b1;
        step(1);
        rx_push = 1'b0;
        chk("rx_full", 8'h01, {7'h00, rx_full});
        rd(A_HOLD);
        chk("rx_one", 8'hA7, rd_q);
        divisor_access = 1'b1;
        wr(A_HOLD, 8'h55);
        rd(A_ISR);
        chk("isr_dlab", 8'h00, rd_q);
        chk("thr_dlab", 8'h00, {7'h00, tx_avail});
        divisor_access = 1'b0;
        wr(A_HOLD, 8'h11);
        wr(A_HOLD, 8'h22);
        pop(8'h11);
        chk("tx_drop", 8'h00, {7'h00, tx_avail});
        broadcast_write_control = 1'b1;
        wr(8'h50, 8'h33);
        broadcast_write_control = 1'b0;
        wr(8'h50, 8'h44);
        pop(8'h33);
        chk("tx_other", 8'h00, {7'h00, tx_avail});
        rd(A_ISR);
        chk("isr_thr_empty", {2'b00, `UOCT_ID_TX_READY}, rd_q);
    endtask
    // infrared pulse widths for both standards and the decoder
    task automatic t_ir;
        wr(A_MCR, 8'h40);
        chk("ir_on", 8'h01, {7'h00, infrared_mode});
        tx_serial = 1'b0;
        for (int s = 0; s < 2; s++) begin
            irda11_select = s[0];
            @(posedge clk);
            while (sample_tick !== 1'b1) @(posedge clk);
            #1;
            tx_bit_start = 1'b1;
            step(1);
            tx_bit_start = 1'b0;
            hi_cnt = 0;
            repeat (30) begin
                step(1);
                hi_cnt += tx_pin;
            end
            chk("ir_pulse", 8'h01, {7'h00, hi_cnt >= 4 * (3 + s) - 2 && hi_cnt <= 4 * (3 + s)});
            chk("ir_tx_idle", 8'h00, {7'h00, tx_pin});
        end
        rx_pin = 1'b1;
        step(3);
        rx_pin = 1'b0;
        step(6);
        chk("ir_rx_pulse", 8'h01, {7'h00, rx_serial});
        step(70);
        chk("ir_rx_idle", 8'h00, {7'h00, rx_serial});
        tx_serial = 1'b1;
        wr(A_MCR, 8'h00);
        chk("ir_off2", 8'h00, {7'h00, infrared_mode});
    endtask

    initial begin
        clk = 1'b0;
        tick_cnt = 2'h0;
        rx_push_data = 8'h5A;
        {sys_rst, clk_en, infrared_default_pin, tx_serial} = 4'hF;
        {soft_rst, broadcast_write_control, divisor_access, enhanced_function_en, fifo_enable, irda11_select,
         rx_line_err, rx_timeout, modem_status_evt, xoff_detect, xon_detect, special_char_detect,
         cts_inactive_evt, rts_inactive_evt, tx_above_trigger, tx_pop, rx_push, tx_bit_start, rx_pin} = '0;
        repeat (12) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        step(6);
        t_reset;
        t_ier;
        t_prio;
        t_fifo;
        t_ir;
        end_sim;
    end
    // watchdog against a hang
    initial begin
        repeat (6000) @(posedge clk);
        failures++;
        end_sim;
    end
endmodule // uoct_channel_tb_top
`default_nettype wire
